/* mss_pkg.sv */
// Constants for the motor speed command select block
//
// Behaviour
// - Speed command comes from pin PWM duty, pin analog level, or serial value.
// - A serially written speed value is accepted as a command source.
// - Input type select zero treats the speed pin as analog voltage.
// - Analog level above full scale clamps the command to maximum.
// - Analog level from the stop threshold to below full scale scales the command linearly.
// - Analog level below the stop threshold commands motor stop.
// - Input type select one treats the speed pin as PWM duty input.
// - PWM mode command is proportional to measured duty, zero to full.
// - PWM input held low for the zero-stop time commands motor stop.
// - Source keeps PWM frequency in selected range; measurement follows that range.
// - Input PWM frequency is independent of the output switching frequency select.
// - Serial priority set takes the command only from the serial value.
package mss_pkg;

   // ==========================================================
   // Widths
   localparam int CMD_W = 16;
   localparam int ADC_W = 12;
   localparam int CNT_W = 24;

   // ==========================================================
   // Encodings
   localparam logic SRC_ANALOG = 1'h0;
   localparam logic SRC_PWM = 1'h1;
   localparam logic [1:0] RANGE_LOW = 2'h0;
   localparam logic [1:0] RANGE_MID = 2'h1;
   localparam logic [1:0] RANGE_HIGH = 2'h2;
   localparam logic [1:0] RANGE_TOP = 2'h3;

   // ==========================================================
   // Fixed values
   localparam logic [CMD_W-1:0] CMD_MAX = 16'hFFFF;
   localparam logic [CMD_W-1:0] CMD_STOP = 16'h0000;
   localparam logic [ADC_W-1:0] ADC_FULL_SCALE_DEF = 12'hFFF;
   localparam logic [ADC_W-1:0] ADC_STOP_DEF = 12'h040;

   // ==========================================================
   // Timing at a 20 MHz core clock
   localparam int CLK_HZ = 20_000_000;
   localparam int ZERO_STOP_TIME_MS = 10;
   localparam int ZERO_STOP_CYC = ZERO_STOP_TIME_MS * (CLK_HZ / 1000);
   // Shortest period per range in core clocks (faster ranges shorter)
   localparam logic [CNT_W-1:0] MIN_PERIOD_LOW = 24'h000FA0;
   localparam logic [CNT_W-1:0] MIN_PERIOD_MID = 24'h0003E8;
   localparam logic [CNT_W-1:0] MIN_PERIOD_HIGH = 24'h0000C8;
   localparam logic [CNT_W-1:0] MIN_PERIOD_TOP = 24'h000028;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
   localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

endpackage : mss_pkg

/* mss_sync2.sv */
// Two flip-flop synchroniser for the speed pin
`timescale 1ns/1ps
module mss_sync2 (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Data
   input wire logic d_in,
   output logic q_out
);
   logic meta_reg;
   logic q_reg;

   // Two stages; first read only by the second
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         meta_reg <= 1'b0;
         q_reg <= 1'b0;
      end else begin
         meta_reg <= d_in;
         q_reg <= meta_reg;
      end
   end

   assign q_out = q_reg;
endmodule : mss_sync2

/* mss_pwm_meter.sv */
// Measures high time and period of the speed pin PWM in core clocks
`timescale 1ns/1ps
module mss_pwm_meter
   import mss_pkg::*;
#(
   parameter int ZERO_STOP_CYCLES = mss_pkg::ZERO_STOP_CYC
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Synchronised pin and range
   input wire logic pin_in,
   input wire logic [1:0] input_frequency_range_select_in,
   // Results
   output logic [mss_pkg::CMD_W-1:0] duty_out,
   output logic duty_valid_out,
   output logic zero_stop_out
);
   import mss_pkg::*;

   // Stop time must fit the low-time counter
   if (ZERO_STOP_CYCLES < 1 || ZERO_STOP_CYCLES >= (1 << CNT_W)) begin : g_bad_zstop
      $error("bad ZERO_STOP_CYCLES");
   end

   localparam logic [CNT_W-1:0] ZSTOP = CNT_W'(ZERO_STOP_CYCLES);

   logic prev_reg, prev_next;
   logic [CNT_W-1:0] high_reg, high_next, per_reg, per_next, low_reg, low_next;
   logic [CMD_W-1:0] duty_reg, duty_next;
   logic valid_reg, valid_next, zstop_reg, zstop_next, seen_reg, seen_next;
   logic [CNT_W-1:0] min_per;
   logic [CNT_W+CMD_W-1:0] prod;

   // Shortest accepted period for the chosen range
   always_comb begin
      case (input_frequency_range_select_in)
         RANGE_LOW: min_per = MIN_PERIOD_LOW;
         RANGE_MID: min_per = MIN_PERIOD_MID;
         RANGE_HIGH: min_per = MIN_PERIOD_HIGH;
         default: min_per = MIN_PERIOD_TOP;
      endcase
   end

   assign prod = (CNT_W+CMD_W)'(high_reg) * (CNT_W+CMD_W)'(CMD_MAX);

   // Period measured rising edge to rising edge
   always_comb begin
      prev_next = pin_in;
      high_next = high_reg;
      per_next = per_reg;
      low_next = low_reg;
      duty_next = duty_reg;
      valid_next = 1'b0;
      zstop_next = zstop_reg;
      seen_next = seen_reg;
      if (per_reg != {CNT_W{1'b1}})
         per_next = per_reg + CNT_ONE;
      if (pin_in && high_reg != {CNT_W{1'b1}})
         high_next = high_reg + CNT_ONE;
      if (pin_in && !prev_reg) begin
         // Rising edge closes one period
         if (seen_reg && per_reg >= min_per) begin
            duty_next = CMD_W'(prod / (CNT_W+CMD_W)'(per_reg));
            valid_next = 1'b1;
         end
         seen_next = 1'b1;
         per_next = CNT_ONE;
         high_next = CNT_ONE;
      end
      // Continuous low timer for the zero-duty stop
      if (pin_in) begin
         low_next = CNT_ZERO;
         zstop_next = 1'b0;
      end else if (low_reg >= ZSTOP - CNT_ONE) begin
         zstop_next = 1'b1;
         duty_next = CMD_STOP;
      end else begin
         low_next = low_reg + CNT_ONE;
      end
      // Full duty: no edges, line held high for the stop time
      if (pin_in && per_reg >= ZSTOP && high_reg >= ZSTOP)
         duty_next = CMD_MAX;
   end

   // Registers
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         prev_reg <= 1'b0;
         high_reg <= CNT_ZERO;
         per_reg <= CNT_ZERO;
         low_reg <= CNT_ZERO;
         duty_reg <= CMD_STOP;
         valid_reg <= 1'b0;
         zstop_reg <= 1'b1;
         seen_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
         high_reg <= high_next;
         per_reg <= per_next;
         low_reg <= low_next;
         duty_reg <= duty_next;
         valid_reg <= valid_next;
         zstop_reg <= zstop_next;
         seen_reg <= seen_next;
      end
   end

   assign duty_out = duty_reg;
   assign duty_valid_out = valid_reg;
   assign zero_stop_out = zstop_reg;
endmodule : mss_pwm_meter

/* mss_speed_select.sv */
// Top of the motor speed command selection block
`timescale 1ns/1ps
module mss_speed_select #(
   parameter int ZERO_STOP_CYCLES = mss_pkg::ZERO_STOP_CYC
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Speed pin, digital view (asynchronous)
   input wire logic speed_pin_in,
   // Analog level of speed pin from converter (same clock)
   input wire logic [mss_pkg::ADC_W-1:0] speed_level_in,
   input wire logic speed_level_valid_in,
   // Configuration
   input wire logic speed_input_type_select_in,
   input wire logic [1:0] input_frequency_range_select_in,
   input wire logic serial_command_priority_in,
   input wire logic [mss_pkg::ADC_W-1:0] analog_full_scale_level_in,
   input wire logic [mss_pkg::ADC_W-1:0] analog_stop_threshold_in,
   input wire logic [1:0] output_frequency_select_in,
   // Serial speed command
   input wire logic [mss_pkg::CMD_W-1:0] serial_speed_in,
   // Results
   output logic [mss_pkg::CMD_W-1:0] speed_cmd_out,
   output logic motor_stop_out,
   output logic [mss_pkg::CMD_W-1:0] pwm_duty_out,
   output logic [1:0] source_out
);
   import mss_pkg::*;

   // ==========================================================
   // Pin synchroniser and duty meter
   logic pin_sync;
   logic [CMD_W-1:0] duty;
   logic zero_stop;

   mss_sync2 u_sync (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .d_in(speed_pin_in),
      .q_out(pin_sync)
   );

   // Output switching select is unrelated to the input meter
   mss_pwm_meter #(.ZERO_STOP_CYCLES(ZERO_STOP_CYCLES)) u_meter (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .pin_in(pin_sync),
      .input_frequency_range_select_in(input_frequency_range_select_in),
      .duty_out(duty),
      .duty_valid_out(),
      .zero_stop_out(zero_stop)
   );

   // ==========================================================
   // Analog level capture and scaling
   logic [ADC_W-1:0] level_reg, level_next;
   logic [CMD_W-1:0] ana_cmd;
   logic [CMD_W+ADC_W-1:0] ana_prod;

   always_comb begin
      level_next = level_reg;
      if (speed_level_valid_in)
         level_next = speed_level_in;
   end

   assign ana_prod = (CMD_W+ADC_W)'(level_reg) * (CMD_W+ADC_W)'(CMD_MAX);

   // Clamp, stop and linear regions
   always_comb begin
      if (level_reg < analog_stop_threshold_in)
         ana_cmd = CMD_STOP;
      else if (level_reg > analog_full_scale_level_in || analog_full_scale_level_in == '0)
         ana_cmd = CMD_MAX;
      else
         ana_cmd = CMD_W'(ana_prod / (CMD_W+ADC_W)'(analog_full_scale_level_in));
   end

   // ==========================================================
   // Source selection
   logic [CMD_W-1:0] cmd_reg, cmd_next, pduty_reg, pduty_next;
   logic stop_reg, stop_next;
   logic [1:0] src_reg, src_next;

   always_comb begin
      pduty_next = duty;
      if (serial_command_priority_in) begin
         cmd_next = serial_speed_in;
         src_next = 2'h2;
      end else if (speed_input_type_select_in == SRC_PWM) begin
         cmd_next = zero_stop ? CMD_STOP : duty;
         src_next = 2'h1;
      end else begin
         cmd_next = ana_cmd;
         src_next = 2'h0;
      end
      stop_next = (cmd_next == CMD_STOP);
   end

   // Registers
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         level_reg <= '0;
         cmd_reg <= CMD_STOP;
         pduty_reg <= CMD_STOP;
         stop_reg <= 1'b1;
         src_reg <= 2'h0;
      end else begin
         level_reg <= level_next;
         cmd_reg <= cmd_next;
         pduty_reg <= pduty_next;
         stop_reg <= stop_next;
         src_reg <= src_next;
      end
   end

   assign speed_cmd_out = cmd_reg;
   assign motor_stop_out = stop_reg;
   assign pwm_duty_out = pduty_reg;
   assign source_out = src_reg;
endmodule : mss_speed_select

/* mss_monitor.sv */
// Port checker of the speed select block
`timescale 1ns/1ps
module mss_monitor #(
   parameter int ZERO_STOP_CYCLES = mss_pkg::ZERO_STOP_CYC
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Inputs
   input wire logic speed_pin_in,
   input wire logic [11:0] speed_level_in,
   input wire logic speed_level_valid_in,
   input wire logic speed_input_type_select_in,
   input wire logic serial_command_priority_in,
   input wire logic [11:0] analog_full_scale_level_in,
   input wire logic [11:0] analog_stop_threshold_in,
   input wire logic [15:0] serial_speed_in,
   // Results
   input wire logic [15:0] speed_cmd_out,
   input wire logic motor_stop_out,
   input wire logic [1:0] source_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   int low_reg;
   int low_next;
   // Pin low time in PWM mode, saturating
   always_comb low_next = (speed_pin_in || !speed_input_type_select_in || serial_command_priority_in) ? 0 :
      (low_reg > ZERO_STOP_CYCLES + 8 ? low_reg : low_reg + 1);
   always_ff @(posedge mclk_in) low_reg <= rst_in ? 0 : low_next;
   sequence s_ana;
      !serial_command_priority_in && !speed_input_type_select_in;
   endsequence
   a_serial_cmd: assert property (serial_command_priority_in |=> speed_cmd_out == $past(serial_speed_in))
      else $error("serial command not taken");
   a_serial_src: assert property (serial_command_priority_in |=> source_out == 2'h2)
      else $error("source not serial");
   a_pwm_src: assert property (!serial_command_priority_in && speed_input_type_select_in |=> source_out == 2'h1)
      else $error("source not pwm");
   a_ana_src: assert property (s_ana |=> source_out == 2'h0)
      else $error("source not analog");
   a_stop_flag: assert property (motor_stop_out == (speed_cmd_out == 16'h0000))
      else $error("stop flag disagrees");
   a_zero_stop: assert property (low_reg > ZERO_STOP_CYCLES + 4 |-> motor_stop_out)
      else $error("no stop after low pin");
   a_ana_stop: assert property ((speed_level_valid_in && speed_level_in < analog_stop_threshold_in) ##0 s_ana ##1 s_ana
      |=> speed_cmd_out == 16'h0000)
      else $error("analog stop missed");
   a_ana_clamp: assert property ((speed_level_valid_in && speed_level_in > analog_full_scale_level_in
      && speed_level_in >= analog_stop_threshold_in) ##0 s_ana ##1 s_ana |=> speed_cmd_out == 16'hFFFF)
      else $error("analog clamp missed");
endmodule : mss_monitor

/* mss_pwm_source.sv */
// Model of the PWM source on the speed pin
`timescale 1ns/1ps
module mss_pwm_source (
   // Clock
   input wire logic mclk_in,
   // Waveform
   input wire logic enable_in,
   input wire logic [15:0] high_in,
   input wire logic [15:0] period_in,
   // Pin
   output logic pin_out
);
   logic [15:0] cnt_reg = 16'h0000;
   initial pin_out = 1'b0;
   // Period set by the bench; once left below the range 2 minimum to check rejection
   always @(negedge mclk_in) begin
      cnt_reg <= (cnt_reg + 16'h0001 >= period_in) ? 16'h0000 : cnt_reg + 16'h0001;
      pin_out <= enable_in && (cnt_reg < high_in);
   end
endmodule : mss_pwm_source

/* mss_speed_select_test.sv */
// Self-checking bench of the speed select block
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, (a), (b)); end end
module mss_speed_select_test;
   import mss_pkg::*;
   // Stop time longer than any low phase of the test waveforms
   localparam int ZS = 300;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic vld = 1'b1, sel_pwm = 1'b0, prio = 1'b0, src_en = 1'b0, stop, pin;
   logic [1:0] frange = 2'h3, ofreq = 2'h0, source;
   logic [ADC_W-1:0] level = 12'h000, fs = 12'hC00, thr = 12'h040;
   logic [CMD_W-1:0] serial = 16'h0000, cmd, duty, hi = 16'h0032, per = 16'h0064;
   logic [31:0] seed = 32'hDBA7;
   int error_cnt = 0, checks = 0, cyc = 0;
   int tbl[$] = '{12'h000, 12'h03F, 12'h040, 12'h600, 12'hBFF, 12'hC00, 12'hC01, 12'hFFF};
   always #25 mclk_in = ~mclk_in;
   mss_pwm_source src_u (.mclk_in(mclk_in), .enable_in(src_en), .high_in(hi), .period_in(per), .pin_out(pin));
   mss_speed_select #(.ZERO_STOP_CYCLES(ZS)) dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .speed_pin_in(pin),
      .speed_level_in(level), .speed_level_valid_in(vld), .speed_input_type_select_in(sel_pwm),
      .input_frequency_range_select_in(frange), .serial_command_priority_in(prio),
      .analog_full_scale_level_in(fs), .analog_stop_threshold_in(thr), .output_frequency_select_in(ofreq),
      .serial_speed_in(serial), .speed_cmd_out(cmd), .motor_stop_out(stop), .pwm_duty_out(duty), .source_out(source));
   // ==========
   // Model and helpers
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   function automatic int exp_ana(input int l);
      if (l < thr) return 0;
      if (l > fs || fs == 0) return 65535;
      return l * 65535 / fs;
   endfunction : exp_ana
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge mclk_in);
   endtask : wait_cyc
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   // Hang guard
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end
   // Main sequence
   initial begin
      int l;
      int d;
      wait_cyc(16);
      `CHK({cmd, stop, duty, source}, {CMD_STOP, 1'b1, CMD_STOP, 2'h0})
      rst_in = 1'b0;
      prio = 1'b1;
      sel_pwm = 1'b1;
      src_en = 1'b1;
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         serial = seed[15:0];
         wait_cyc(1);
         `CHK(cmd, serial)
         `CHK(source, 2'h2)
      end
      prio = 1'b0;
      sel_pwm = 1'b0;
      for (int i = 0; i < 14; i++) begin
         seed = xs(seed);
         l = (i < 8) ? tbl[i] : int'(seed[11:0]);
         level = l[11:0];
         wait_cyc(2);
         `CHK(cmd, CMD_W'(exp_ana(l)))
         `CHK(stop, exp_ana(l) == 0)
      end
      sel_pwm = 1'b1;
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         ofreq = seed[1:0];
         hi = (i == 0) ? 16'h0001 : (i == 1) ? 16'h0063 : 16'h0001 + 16'(seed[22:16] % 98);
         wait_cyc(310);
         d = hi * 65535 / 100;
         `CHK(duty, CMD_W'(d))
         `CHK(cmd, CMD_W'(d))
      end
      frange = 2'h2;
      hi = 16'h0019;
      wait_cyc(310);
      `CHK(duty, CMD_W'(d))
      per = 16'h00FA;
      wait_cyc(760);
      d = 25 * 65535 / 250;
      `CHK(duty, CMD_W'(d))
      // Line held high with no edges reads as full duty
      hi = 16'h00FA;
      wait_cyc(ZS + 20);
      `CHK(duty, CMD_MAX)
      `CHK(cmd, CMD_MAX)
      src_en = 1'b0;
      wait_cyc(ZS - 10);
      `CHK(cmd, CMD_MAX)
      wait_cyc(20);
      `CHK({cmd, stop, duty}, {CMD_STOP, 1'b1, CMD_STOP})
      wrap_up();
   end
endmodule : mss_speed_select_test
bind mss_speed_select mss_monitor #(.ZERO_STOP_CYCLES(ZERO_STOP_CYCLES)) mon_u (.mclk_in, .rst_in, .speed_pin_in,
   .speed_level_in, .speed_level_valid_in, .speed_input_type_select_in, .serial_command_priority_in,
   .analog_full_scale_level_in, .analog_stop_threshold_in, .serial_speed_in, .speed_cmd_out, .motor_stop_out,
   .source_out);
